// >>> hw/adc_ctrl.v
// converter control: selection buffer and lock, start logic, sar sequencer,
// sleep-started conversions, apb registers and the done interrupt
// assumes an external comparator (COMP, asynchronous) and a dac fed by
// SAR_CODE; CPU_HALTED and SLEEP_MODE come from same-clock cpu logic
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

// Operation
// R1 - buffer selection, copy while no conversion
// R2 - freeze active selection once conversion begins
// R3 - resume copying in final converter cycle
// R4 - start on next converter clock edge
// R5 - software waits one converter cycle before reselecting
// R6 - selection writes apply in defined safe windows
// R7 - free running: next conversion keeps old channel
// R8 - over-range input gives full-scale code
// R9 - software discards first result after reference change
// R10 - software prepares converter before low-noise sleep
// R11 - sleep entry starts conversion once cpu halted
// R12 - completion interrupt raised even after other wake
// R13 - other sleep modes leave converter enabled
// R14 - start bit set during conversion, cleared after
// R15 - free running restarts at once, start stays
// R16 - result and done flag update together
// R17 - trigger start locks selection like software start
// R18 - disabled converter: selection tracks, no lock
module adc_ctrl (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        TRIGGER,
  input  wire        COMP,
  input  wire        CPU_HALTED,
  input  wire [2:0]  SLEEP_MODE,
  output reg  [3:0]  CHANNEL_SELECT,
  output reg  [1:0]  REFERENCE_SELECT,
  output reg  [9:0]  SAR_CODE,
  output reg         SAMPLE,
  output wire        CONVERTER_ON,
  output wire        IRQ
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_CONV  = 3'b100;
  // reset image of the selection buffer, split into its two fields
  localparam [7:0] SEL_INIT = `SEL_RESET;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [4:0] cyc_q;
  reg        first_q;
  reg        lock_q;
  reg  [3:0] chan_buf_q;
  reg  [1:0] ref_buf_q;
  reg        converter_enable_q;
  reg        start_conversion_bit_q;
  reg        auto_trigger_enable_q;
  reg        conversion_done_flag_q;
  reg        int_mask_q;
  reg        free_run_q;
  reg  [9:0] result_q;
  reg        trig_prev_q;
  reg        halted_prev_q;
  wire       trig_s;
  wire       comp_s;
  wire       tick;
  wire       wr;
  wire       setup;
  wire       mapped;
  wire       sw_start;
  wire       trig_start;
  wire       sleep_start;
  wire       any_start;
  wire [4:0] conv_len;
  wire [4:0] sample_at;
  wire       last_cyc;
  wire       finish;
  wire       bit_phase;
  wire [3:0] bit_idx;
  wire       free_running;
  wire       done_w1c;
  wire [4:0] bit_diff;

  // pins from outside the clock domain
  sync2 u_sync_trig (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (TRIGGER),
    .dout  (trig_s)
  );

  sync2 u_sync_comp (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (COMP),
    .dout  (comp_s)
  );

  // divider held clear while disabled; a trigger restarts it so the
  // delay from trigger to start is fixed
  conv_tick u_tick (
    .clk   (CLK),
    .rst_b (RST_B),
    .clear (~converter_enable_q | trig_start),
    .tick  (tick)
  );

  // apb decode; the slave never waits
  assign setup   = PSEL & ~PENABLE;
  assign wr      = PSEL & PENABLE & PWRITE & mapped;
  assign PREADY  = 1'b1;
  assign mapped  = (PADDR == `OFF_INPUT_SELECT)   |
                   (PADDR == `OFF_CONTROL_STATUS) |
                   (PADDR == `OFF_RESULT)         |
                   (PADDR == `OFF_ACTIVE_SELECT)  |
                   (PADDR == `OFF_TRIGGER_CFG)    |
                   (PADDR == `OFF_INT_STATUS)     |
                   (PADDR == `OFF_INT_MASK);
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // start sources; trigger and sleep only act on an enabled, idle converter, software start only needs its write's enable bit
  assign free_running = auto_trigger_enable_q & free_run_q;
  assign sw_start     = wr & (PADDR == `OFF_CONTROL_STATUS) &
                        PWDATA[`CTL_START] & PWDATA[`CTL_ENABLE];
  // an edge while busy is ignored
  assign trig_start   = auto_trigger_enable_q & ~free_run_q &
                        converter_enable_q & trig_s & ~trig_prev_q &
                        (state_q == ST_IDLE);
  // only idle and noise-reduction sleep start a conversion; other
  // modes change nothing here, software must disable first
  assign sleep_start  = CPU_HALTED & ~halted_prev_q &          // R11 R13
                        converter_enable_q & (state_q == ST_IDLE) &
                        ((SLEEP_MODE == `SLEEP_IDLE) |
                         (SLEEP_MODE == `SLEEP_NOISE_RED));
  assign any_start    = sw_start | trig_start | sleep_start;

  // conversion length, longer for the first after enable
  assign conv_len  = first_q ? `CONV_LEN_FIRST   : `CONV_LEN_NORMAL;
  assign sample_at = first_q ? `SAMPLE_AT_FIRST  : `SAMPLE_AT_NORMAL;
  assign last_cyc  = (state_q == ST_CONV) & (cyc_q == conv_len - 5'h01);
  assign finish    = last_cyc & tick;

  // ten bit decisions end one cycle before the last
  assign bit_phase = (state_q == ST_CONV) &
                     (cyc_q >= conv_len - 5'h0b) &
                     (cyc_q <= conv_len - 5'h02);
  // distance to the last decision cycle; bit_phase keeps it within 0..9,
  // so the low four bits carry all of it
  assign bit_diff  = conv_len - 5'h02 - cyc_q;
  assign bit_idx   = (bit_phase) ? bit_diff[3:0] : 4'h0;

  assign done_w1c = (wr & (PADDR == `OFF_CONTROL_STATUS) &
                     PWDATA[`CTL_DONE]) |
                    (wr & (PADDR == `OFF_INT_STATUS) &
                     PWDATA[`INT_DONE]);

  // sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (any_start)
          state_d = ST_ARMED;
      end
      ST_ARMED: begin
        if (tick)
          state_d = ST_CONV;                                   // R4
      end
      ST_CONV: begin
        if (finish)
          state_d = free_running ? ST_CONV : ST_IDLE;          // R15
      end
      default: state_d = ST_IDLE;
    endcase
    // turning the converter off ends any conversion; a write that enables
    // and starts in one go must still arm the sequencer
    if (!converter_enable_q && !sw_start)
      state_d = ST_IDLE;
  end

  // sequencer state, cycle count and first-conversion marker
  always @(posedge CLK) begin
    if (!RST_B) begin
      state_q <= ST_IDLE;
      cyc_q   <= 5'h00;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_q != ST_CONV || finish)
        cyc_q <= 5'h00;
      else if (tick)
        cyc_q <= cyc_q + 5'h01;
      if (!converter_enable_q)
        first_q <= 1'b1;
      else if (finish)
        first_q <= 1'b0;
    end
  end

  // selection lock: taken when the conversion begins, however started,
  // dropped in the last converter cycle and whenever disabled
  // clearing it on disable means a re-enable never inherits a stale lock
  always @(posedge CLK) begin
    if (!RST_B)
      lock_q <= 1'b0;
    else if (!converter_enable_q)
      lock_q <= 1'b0;                                          // R18
    else if (state_q == ST_ARMED && tick)
      lock_q <= 1'b1;                                          // R2 R17
    else if (finish && free_running)
      lock_q <= 1'b1;                                          // R7
    else if (last_cyc)
      lock_q <= 1'b0;                                          // R3
  end

  // active selection follows the buffer whenever unlocked, but not on the tick that takes the lock; in free
  // running the lock returns at completion, so a change made after it
  // reaches only the conversion after next
  always @(posedge CLK) begin
    if (!RST_B) begin
      CHANNEL_SELECT   <= 4'h0;
      REFERENCE_SELECT <= 2'h0;
    end else if (!lock_q &&
                 !(state_q == ST_ARMED && tick)) begin
      CHANNEL_SELECT   <= chan_buf_q;                          // R1 R6
      REFERENCE_SELECT <= ref_buf_q;                           // R1 R6
    end
  end

  // successive approximation; a comparator stuck high gives all ones
  // the comparator passes two flops: two clk of a converter cycle's eight
  always @(posedge CLK) begin
    if (!RST_B) begin
      SAR_CODE <= 10'h000;
      SAMPLE   <= 1'b0;
      result_q <= 10'h000;
    end else begin
      SAMPLE <= (state_q == ST_CONV) & (cyc_q == sample_at);
      if (state_q == ST_CONV && cyc_q == conv_len - 5'h0c && tick)
        SAR_CODE <= 10'h200;
      else if (bit_phase && tick) begin
        if (!comp_s)
          SAR_CODE[bit_idx] <= 1'b0;                           // R8
        if (bit_idx != 4'h0)
          SAR_CODE[bit_idx - 4'h1] <= 1'b1;
      end
      if (finish)
        result_q <= SAR_CODE;                                  // R16
    end
  end

  // control bits, buffer and flags; hardware set wins over w1c
  always @(posedge CLK) begin
    if (!RST_B) begin
      chan_buf_q             <= SEL_INIT[`SEL_CHAN_HI:`SEL_CHAN_LO];
      ref_buf_q              <= SEL_INIT[`SEL_REF_HI:`SEL_REF_LO];
      converter_enable_q     <= 1'b0;
      start_conversion_bit_q <= 1'b0;
      auto_trigger_enable_q  <= 1'b0;
      conversion_done_flag_q <= 1'b0;
      int_mask_q             <= 1'b0;
      free_run_q             <= 1'b0;
      trig_prev_q            <= 1'b0;
      halted_prev_q          <= 1'b0;
    end else begin
      trig_prev_q   <= trig_s;
      halted_prev_q <= CPU_HALTED;
      // writes land in the buffer only; the lock decides when they act
      if (wr && PADDR == `OFF_INPUT_SELECT) begin
        chan_buf_q <= PWDATA[`SEL_CHAN_HI:`SEL_CHAN_LO];       // R1
        ref_buf_q  <= PWDATA[`SEL_REF_HI:`SEL_REF_LO];
      end
      if (wr && PADDR == `OFF_CONTROL_STATUS) begin
        converter_enable_q    <= PWDATA[`CTL_ENABLE];
        auto_trigger_enable_q <= PWDATA[`CTL_AUTO];
        int_mask_q            <= PWDATA[`CTL_IE];
      end
      if (wr && PADDR == `OFF_INT_MASK)
        int_mask_q <= PWDATA[`INT_DONE];
      if (wr && PADDR == `OFF_TRIGGER_CFG)
        free_run_q <= PWDATA[`TRG_FREE];
      // start bit reads one from request to completion
      if (wr && PADDR == `OFF_CONTROL_STATUS && !PWDATA[`CTL_ENABLE])
        start_conversion_bit_q <= 1'b0;
      else if (any_start)
        start_conversion_bit_q <= 1'b1;                        // R14
      else if (finish && !free_running)
        start_conversion_bit_q <= 1'b0;                        // R14
      else if (!converter_enable_q)
        start_conversion_bit_q <= 1'b0;
      // flag set with the result, whatever woke the cpu meanwhile
      if (finish)
        conversion_done_flag_q <= 1'b1;                        // R12 R16
      else if (done_w1c)
        conversion_done_flag_q <= 1'b0;
    end
  end

  // enable reaches the analog side straight from its register
  assign CONVERTER_ON = converter_enable_q;
  // level interrupt, also the wake request from sleep
  assign IRQ = conversion_done_flag_q & int_mask_q;            // R12

  // read data captured in the setup cycle, valid in the access cycle
  always @(posedge CLK) begin
    if (!RST_B)
      PRDATA <= 32'h0000_0000;
    else if (setup) begin
      case (PADDR)
        `OFF_INPUT_SELECT:
          PRDATA <= {24'h000000, ref_buf_q, 2'h0, chan_buf_q};
        `OFF_CONTROL_STATUS:
          PRDATA <= {24'h000000, converter_enable_q,
                     start_conversion_bit_q, auto_trigger_enable_q,
                     conversion_done_flag_q, int_mask_q, 3'h0};
        `OFF_RESULT:
          PRDATA <= {22'h000000, result_q};
        `OFF_ACTIVE_SELECT:
          PRDATA <= {24'h000000, REFERENCE_SELECT, 1'b0, lock_q,
                     CHANNEL_SELECT};
        `OFF_TRIGGER_CFG:
          PRDATA <= {31'h00000000, free_run_q};
        `OFF_INT_STATUS:
          PRDATA <= {31'h00000000, conversion_done_flag_q};
        `OFF_INT_MASK:
          PRDATA <= {31'h00000000, int_mask_q};
        default:
          PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule // adc_ctrl

`default_nettype wire

// >>> hw/adc_ctrl_defs.vh
// register map, field positions, reset values and cycle counts for the
// converter control block; definitions only, included by bare name
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// register byte offsets (apb, one 32-bit word each)
`define OFF_INPUT_SELECT   8'h00
`define OFF_CONTROL_STATUS 8'h04
`define OFF_RESULT         8'h08
`define OFF_ACTIVE_SELECT  8'h0c
`define OFF_TRIGGER_CFG    8'h10
`define OFF_INT_STATUS     8'h14
`define OFF_INT_MASK       8'h18

// input_select_register fields
`define SEL_REF_HI   7
`define SEL_REF_LO   6
`define SEL_CHAN_HI  3
`define SEL_CHAN_LO  0
`define SEL_RESET    8'h00

// converter_control_status fields
`define CTL_ENABLE   7
`define CTL_START    6
`define CTL_AUTO     5
`define CTL_DONE     4
`define CTL_IE       3

// trigger configuration: 1 selects the done flag (free running)
`define TRG_FREE     0

// interrupt status / mask bit
`define INT_DONE     0

// sleep mode codes seen on the cpu side
`define SLEEP_IDLE        3'h0
`define SLEEP_NOISE_RED   3'h1

// converter clock: system clock divided by this count
`define ADC_DIV           5'h08
// converter clock cycles per conversion, and sample points
`define CONV_LEN_NORMAL   5'h0d
`define CONV_LEN_FIRST    5'h19
`define SAMPLE_AT_NORMAL  5'h01
`define SAMPLE_AT_FIRST   5'h0d

`endif

// >>> hw/sync2.v
// two-flop synchroniser for one level from outside the clock domain
// assumes the input is a plain level with no timing relation to clk
`timescale 1ns/1ps
`default_nettype none

module sync2 (
  input  wire clk,
  input  wire rst_b,
  input  wire din,
  output reg  dout
);

  reg meta_q;

  // first flop feeds only the second
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // sync2

`default_nettype wire

// >>> hw/conv_tick.v
// divider making the converter clock as a one-cycle tick
// assumes clear is a same-domain level; the tick restarts from clear
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

module conv_tick (
  input  wire clk,
  input  wire rst_b,
  input  wire clear,
  output wire tick
);

  reg [4:0] cnt_q;

  // tick marks the rising edge of the divided clock
  assign tick = (cnt_q == `ADC_DIV - 5'h01);

  always @(posedge clk) begin
    if (!rst_b || clear)
      cnt_q <= 5'h00;
    else if (tick)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_q + 5'h01;
  end

endmodule // conv_tick

`default_nettype wire

// >>> testbench/adc_ctrl_asserts.sv
// concurrent checks on the ports of the converter control block
// assumes the apb master keeps setup and access phases in order
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

module adc_ctrl_asserts (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CPU_HALTED,
  input wire logic [3:0]  CHANNEL_SELECT,
  input wire logic [1:0]  REFERENCE_SELECT,
  input wire logic        SAMPLE,
  input wire logic        CONVERTER_ON,
  input wire logic        IRQ
);
  // bus phase decode shared by several checks
  wire acc    = PSEL && PENABLE;
  wire wr     = acc && PWRITE;
  wire mapped = (PADDR[1:0] == 2'h0) && (PADDR <= 8'h18);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_ready_always: assert property (PREADY)
    else $error("pready low");
  a_err_unmapped: assert property (acc |-> PSLVERR == !mapped)
    else $error("pslverr does not match address decode");
  a_read_unmapped: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
    else $error("read data moved outside a setup cycle");
  // two cycles: buffer takes the write, then the active copy follows
  a_sel_tracks: assert property (wr && PADDR == `OFF_INPUT_SELECT && !CONVERTER_ON
    |-> ##2 CHANNEL_SELECT == $past(PWDATA[3:0], 2)
    && REFERENCE_SELECT == $past(PWDATA[7:6], 2))
    else $error("selection did not follow buffer while off");
  a_sel_frozen: assert property (SAMPLE && $past(SAMPLE)
    |-> $stable(CHANNEL_SELECT) && $stable(REFERENCE_SELECT))
    else $error("selection changed while sampling");
  a_sample_width: assert property ($rose(SAMPLE) |-> SAMPLE[*8] ##1 !SAMPLE)
    else $error("sample window not one converter cycle");
  a_enable_write: assert property (wr && PADDR == `OFF_CONTROL_STATUS
    |=> CONVERTER_ON == $past(PWDATA[`CTL_ENABLE]))
    else $error("enable output does not follow write");
  a_mask_off: assert property (wr && ((PADDR == `OFF_INT_MASK && !PWDATA[0])
    || (PADDR == `OFF_CONTROL_STATUS && !PWDATA[`CTL_IE])) |=> !IRQ)
    else $error("irq high after mask cleared");
  a_off_idle: assert property (!CONVERTER_ON && !$past(CONVERTER_ON)
    && !$past(CONVERTER_ON, 2) |-> !SAMPLE)
    else $error("sampling while converter off");
  a_sleep_keeps_on: assert property ($rose(CPU_HALTED) && !wr
    |=> CONVERTER_ON == $past(CONVERTER_ON))
    else $error("sleep entry changed enable");

  c_sample: cover property ($rose(SAMPLE));
  c_irq: cover property ($rose(IRQ));
  c_sleep: cover property ($rose(CPU_HALTED) && CONVERTER_ON);
endmodule // adc_ctrl_asserts

bind adc_ctrl adc_ctrl_asserts i_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CPU_HALTED(CPU_HALTED), .CHANNEL_SELECT(CHANNEL_SELECT),
  .REFERENCE_SELECT(REFERENCE_SELECT), .SAMPLE(SAMPLE),
  .CONVERTER_ON(CONVERTER_ON), .IRQ(IRQ));
`default_nettype wire

// >>> testbench/test_adc_ctrl.sv
// self-checking bench for the converter control block over apb
// assumes the defs header is on the include path; comparator is modelled
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

module test_adc_ctrl;
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic        TRIGGER = 1'b0;
  logic        COMP = 1'b0;
  logic        CPU_HALTED = 1'b0;
  logic [2:0]  SLEEP_MODE = 3'h0;
  wire  [31:0] PRDATA;
  wire  [3:0]  CHANNEL_SELECT;
  wire  [1:0]  REFERENCE_SELECT;
  wire  [9:0]  SAR_CODE;
  wire         PREADY, PSLVERR, SAMPLE, CONVERTER_ON, IRQ;
  logic [10:0] vin = 11'h0;  // input level; 11 bits to go past full scale
  logic [31:0] rv;
  logic        er;
  integer      n_mismatch = 0;
  integer      checked = 0;
  integer      i;
  integer      m;

  always #5 CLK = ~CLK;
  // comparator stand-in, registered so it changes only after an edge
  always @(posedge CLK) COMP <= ({1'b0, SAR_CODE} <= vin);

  adc_ctrl i_dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIGGER(TRIGGER), .COMP(COMP),
    .CPU_HALTED(CPU_HALTED), .SLEEP_MODE(SLEEP_MODE),
    .CHANNEL_SELECT(CHANNEL_SELECT), .REFERENCE_SELECT(REFERENCE_SELECT),
    .SAR_CODE(SAR_CODE), .SAMPLE(SAMPLE), .CONVERTER_ON(CONVERTER_ON),
    .IRQ(IRQ));

  task chk(input string nm, input [31:0] e, input [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; an idle edge first keeps drivers from double assigning
  task req(input [7:0] a, input [31:0] d, input w);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rv = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    req(a, d, 1'b1);
  endtask

  task rdc(input string nm, input [7:0] a, input [31:0] e);
    req(a, 32'h0, 1'b0);
    chk(nm, e, rv);
  endtask

  // write, let the registers settle, then look at the interrupt line
  task wchk(input [7:0] a, input [31:0] d, input [31:0] e);
    wr(a, d);
    repeat (2) @(posedge CLK);
    chk("irq", e, 32'(IRQ));
  endtask

  task wait_irq;
    i = 0;
    while (IRQ !== 1'b1 && i < 600) begin
      @(posedge CLK);
      i = i + 1;
    end
    chk("irq raised", 32'h1, 32'(IRQ));
  endtask

  task final_report;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    for (i = 0; i <= 24; i = i + 4) rdc("reset value", i[7:0], 32'h0);
    rdc("unmapped read", 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    // converter off: active selection follows the buffer
    wr(`OFF_INPUT_SELECT, 32'hc5);
    repeat (2) @(posedge CLK);
    chk("chan off", 32'h5, 32'(CHANNEL_SELECT));
    rdc("active sel", `OFF_ACTIVE_SELECT, 32'hc5);
    // single conversion with a reselect two converter cycles in
    vin = 11'h2b6;
    wr(`OFF_CONTROL_STATUS, 32'hc8);
    rdc("start busy", `OFF_CONTROL_STATUS, 32'hc8);
    repeat (20) @(posedge CLK);
    wr(`OFF_INPUT_SELECT, 32'h42);
    repeat (2) @(posedge CLK);
    chk("locked chan", 32'h5, 32'(CHANNEL_SELECT));
    rdc("lock bit", `OFF_ACTIVE_SELECT, 32'hd5);
    wait_irq;
    chk("new chan", 32'h2, 32'(CHANNEL_SELECT));
    rdc("result", `OFF_RESULT, 32'h2b6);
    rdc("done", `OFF_CONTROL_STATUS, 32'h98);
    wchk(`OFF_INT_MASK, 32'h0, 32'h0);
    wchk(`OFF_INT_MASK, 32'h1, 32'h1);
    wchk(`OFF_INT_STATUS, 32'h1, 32'h0);
    // first result after the reference switch is thrown away unread
    wr(`OFF_CONTROL_STATUS, 32'hc8);
    wait_irq;
    wr(`OFF_INT_STATUS, 32'h1);
    // input above the reference saturates the code
    vin = 11'h5ff;
    wr(`OFF_CONTROL_STATUS, 32'hc8);
    wait_irq;
    rdc("full scale", `OFF_RESULT, 32'h3ff);
    wr(`OFF_INT_STATUS, 32'h1);
    // free running: a reselect after a completion skips one conversion
    vin = 11'h0f0;
    wr(`OFF_TRIGGER_CFG, 32'h1);
    wr(`OFF_CONTROL_STATUS, 32'he8);
    wait_irq;
    wr(`OFF_INPUT_SELECT, 32'h47);
    wr(`OFF_INT_STATUS, 32'h1);
    chk("old chan", 32'h2, 32'(CHANNEL_SELECT));
    rdc("start stays", `OFF_CONTROL_STATUS, 32'he8);
    wait_irq;
    chk("next chan", 32'h7, 32'(CHANNEL_SELECT));
    rdc("free result", `OFF_RESULT, 32'h0f0);
    wr(`OFF_CONTROL_STATUS, 32'h0);
    wr(`OFF_TRIGGER_CFG, 32'h0);
    rdc("aborted", `OFF_CONTROL_STATUS, 32'h10);
    rdc("unlocked", `OFF_ACTIVE_SELECT, 32'h47);
    // sleep entry in idle and noise modes; cpu wakes early each time
    vin = 11'h1a5;
    wr(`OFF_INT_STATUS, 32'h1);
    wr(`OFF_CONTROL_STATUS, 32'h88);
    for (m = 0; m < 2; m = m + 1) begin
      SLEEP_MODE <= m[2:0];
      CPU_HALTED <= 1'b1;
      repeat (40) @(posedge CLK);
      CPU_HALTED <= 1'b0;
      wait_irq;
      rdc("sleep result", `OFF_RESULT, 32'h1a5);
      wr(`OFF_INT_STATUS, 32'h1);
    end
    // sleep mode 2 starts nothing and leaves the converter on
    SLEEP_MODE <= 3'h2;
    CPU_HALTED <= 1'b1;
    repeat (300) @(posedge CLK);
    chk("no sleep start", 32'h0, 32'(IRQ));
    chk("still on", 32'h1, 32'(CONVERTER_ON));
    CPU_HALTED <= 1'b0;
    // pin trigger locks the selection like a software start
    wr(`OFF_CONTROL_STATUS, 32'ha8);
    TRIGGER <= 1'b1;
    repeat (30) @(posedge CLK);
    wr(`OFF_INPUT_SELECT, 32'h03);
    repeat (2) @(posedge CLK);
    chk("trig lock", 32'h7, 32'(CHANNEL_SELECT));
    rdc("trig busy", `OFF_CONTROL_STATUS, 32'he8);
    wait_irq;
    chk("trig chan", 32'h3, 32'(CHANNEL_SELECT));
    TRIGGER <= 1'b0;
    final_report;
  end

  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule // test_adc_ctrl
`default_nettype wire
